//--- hdl/fail_out_pkg.sv
// Constants shared by the fail output signalling block.
package fail_out_pkg;
   // Register word offsets (byte addresses).
   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] GPIO_OFS  = 8'h04;
   localparam logic [7:0] STAT_OFS  = 8'h08;
   localparam logic [7:0] WAKE_OFS  = 8'h0c;
   localparam logic [7:0] LVL_OFS   = 8'h10;
   // Control register fields.
   localparam int FORCE_BIT  = 0;
   localparam int DUTY_LSB   = 1;
   localparam int OVEN_BIT   = 3;
   localparam int CFG_LSB    = 4;
   // Pin control fields, two bits of function per pin, then switch bits.
   localparam int SW_LSB     = 4;
   // Status fields.
   localparam int FAIL_BIT   = 0;
   localparam int MISS_BIT   = 1;
   localparam int HOLD_BIT   = 2;
   // Reset values.
   localparam logic [1:0] DUTY_RST = 2'h0;
   localparam logic [1:0] CFG_RST  = 2'h0;
   localparam logic [1:0] FN_RST   = 2'h0;
   // Pin functions.
   localparam logic [1:0] FN_FAIL = 2'h0;
   localparam logic [1:0] FN_WAKE = 2'h1;
   localparam logic [1:0] FN_LS   = 2'h2;
   localparam logic [1:0] FN_HS   = 2'h3;
   // Operating modes of the chip, given on the mode input.
   localparam int         MODE_W       = 2;
   localparam logic [1:0] MODE_NORMAL  = 2'h0;
   localparam logic [1:0] MODE_STOP    = 2'h1;
   localparam logic [1:0] MODE_SLEEP   = 2'h2;
   localparam logic [1:0] MODE_FSAFE   = 2'h3;
   // Timing.
   localparam longint CLK_HZ        = 100000000;
   localparam longint BLINK_CHZ     = 125;
   localparam longint PWM_HZ        = 100;
   localparam longint BLINK_HALF_CYC = CLK_HZ * 100 / (BLINK_CHZ * 2);
   localparam longint PWM_CYC       = CLK_HZ / PWM_HZ;
   localparam int     DUTY_DIV      = 40;
   localparam logic [2:0] UV_LIMIT  = 3'h3;
endpackage

//--- hdl/fail_out_signaling.sv
// Fail output signalling with alternate pin functions, AHB-Lite registers.
//
// What this block does
// - Watchdog failure activates outputs: second one in configs 3,4, first in 1,2.
// - Core supply overvoltage activates outputs only with overvoltage reset enabled.
// - Fourth consecutive core supply undervoltage event activates the outputs.
// - Every failure activation except the first watchdog failure in configuration 2 sets the fail flag in the device status register.
// - Activation also requests fail-safe mode; watchdog cases depend on configuration.
// - The force bit turns the outputs on for test, independent of failures.
// - Without failure conditions software can turn the outputs off by register.
// - Outputs release only after conditions vanish and software clears the flag.
// - After a watchdog failure a good trigger, clearing the miss flag, is needed too.
// - Miss flag also clears on sleep, non-watchdog fail-safe, or stop watchdog off.
// - In configuration 2 the first watchdog failure leaves the fail flag clear.
// - Three open-drain active-low outputs switch on together; static one stays low.
// - The blinking output runs at 1.25 Hz with half duty.
// - The dimmed output runs a 100 Hz PWM, 20 percent by default.
// - Duty select picks 20, 10, 5 or 2.5 percent; reset picks 20.
// - Blink and dimmed pins default to fail outputs; may become wake, LS, HS.
// - A pin set as wake input records edges in the second wake status register, except in fail-safe.
// - In normal and stop modes the level register shows both pin levels.
// - The second pin level bit is also the test strap level bit.
// - Switch pins keep their setting in stop and turn off in sleep, fail-safe.
`timescale 1ns/1ps
module fail_out_signaling #(
   parameter longint BLINK_HALF = fail_out_pkg::BLINK_HALF_CYC,
   parameter longint PWM_PERIOD = fail_out_pkg::PWM_CYC
) (
   input  wire logic                            hclk,
   input  wire logic                            hresetn,
   input  wire logic                            hsel,
   input  wire logic [31:0]                     haddr,
   input  wire logic [1:0]                      htrans,
   input  wire logic                            hwrite,
   input  wire logic [2:0]                      hsize,
   input  wire logic [31:0]                     hwdata,
   input  wire logic                            hready,
   output logic [31:0]                          hrdata,
   output logic                                 hreadyout,
   output logic                                 hresp,
   input  wire logic [fail_out_pkg::MODE_W-1:0] sbc_mode,
   input  wire logic                            wdog_miss_flag_evt,
   input  wire logic                            wd_trig_ok,
   input  wire logic                            wd_off_in_stop,
   input  wire logic                            sleep_entry,
   input  wire logic                            thermal_stage_two,
   input  wire logic                            core_supply_short,
   input  wire logic                            core_supply_ov,
   input  wire logic                            core_supply_uv_evt,
   input  wire logic                            core_supply_uv_ok,
   input  wire logic                            blink_pin_in,
   input  wire logic                            dimmed_out_test_strap_pin,
   output logic                                 static_fail_out_oe_n,
   output logic                                 blink_fail_out_o,
   output logic                                 blink_fail_out_oe_n,
   output logic                                 dimmed_fail_out_o,
   output logic                                 dimmed_fail_out_oe_n,
   output logic                                 failsafe_req
);
   import fail_out_pkg::*;

   typedef struct packed {
      logic             rdy;
      logic [31:0]      rdata;
      logic             wpend;
      logic [7:0]       waddr;
      logic             force_on;
      logic [1:0]       duty;
      logic             ov_en;
      logic [1:0]       cfg;
      logic [1:0][1:0]  fn;
      logic [1:0]       sw;
      logic             fail_flag;
      logic             miss;
      logic             hold;
      logic [1:0]       wd_cnt;
      logic [2:0]       uv_cnt;
      logic             fsafe;
      logic [1:0]       wake2;
      logic [1:0]       lvl;
      logic [1:0]       prev;
      logic [31:0]      blink_cnt;
      logic             blink_ph;
      logic [31:0]      pwm_cnt;
      logic             fail_out_force;
      logic             st_oe_n;
      logic [1:0]       gp_o;
      logic [1:0]       gp_oe_n;
   } state_s;

   localparam logic [31:0] BLINK_LAST = 32'(BLINK_HALF - 1);
   localparam logic [31:0] PWM_LAST   = 32'(PWM_PERIOD - 1);
   localparam logic [31:0] DUTY_STEP  = 32'(PWM_PERIOD / DUTY_DIV);

   state_s s_reg;
   state_s s_next;

   logic [1:0]  pins;
   logic        addr_ph;
   logic        cond;
   logic        wd_act;
   logic        wd_flag_ok;
   logic        other_evt;
   logic        uv4;
   logic [31:0] thr;
   logic        lamp_b;
   logic        lamp_d;
   logic [1:0]  lamp;

   assign pins    = {dimmed_out_test_strap_pin, blink_pin_in};
   assign addr_ph = hsel && hready && htrans[1];

   always_comb begin
      s_next = s_reg;
      // Bus: read data is fetched in the address phase so it leaves a flop.
      s_next.rdy   = 1'b1;
      s_next.wpend = addr_ph && hwrite;
      s_next.waddr = haddr[7:0];
      s_next.rdata = 32'h0;
      if (addr_ph && !hwrite) begin
         if (haddr[7:0] == CTRL_OFS) begin
            s_next.rdata = {26'h0, s_reg.cfg, s_reg.ov_en, s_reg.duty, s_reg.force_on};
         end else if (haddr[7:0] == GPIO_OFS) begin
            s_next.rdata = {26'h0, s_reg.sw, s_reg.fn};
         end else if (haddr[7:0] == STAT_OFS) begin
            s_next.rdata = {29'h0, s_reg.hold, s_reg.miss, s_reg.fail_flag};
         end else if (haddr[7:0] == WAKE_OFS) begin
            s_next.rdata = {30'h0, s_reg.wake2};
         end else if (haddr[7:0] == LVL_OFS) begin
            s_next.rdata = {30'h0, s_reg.lvl};
         end else begin
            s_next.rdata = 32'h0;
         end
      end

      // Failure detection.
      cond       = thermal_stage_two || core_supply_short || (core_supply_ov && s_reg.ov_en);
      uv4        = core_supply_uv_evt && (s_reg.uv_cnt == UV_LIMIT);
      other_evt  = cond || uv4;
      wd_act     = wdog_miss_flag_evt && (!s_reg.cfg[1] || (s_reg.wd_cnt != 2'h0));
      wd_flag_ok = !((s_reg.cfg == 2'h1) && (s_reg.wd_cnt == 2'h0));

      if (core_supply_uv_ok) begin
         s_next.uv_cnt = 3'h0;
      end else if (uv4) begin
         s_next.uv_cnt = 3'h0;
      end else if (core_supply_uv_evt) begin
         s_next.uv_cnt = s_reg.uv_cnt + 3'h1;
      end
      if (wd_trig_ok) begin
         s_next.wd_cnt = 2'h0;
      end else if (wdog_miss_flag_evt && (s_reg.wd_cnt != 2'h2)) begin
         s_next.wd_cnt = s_reg.wd_cnt + 2'h1;
      end

      // Writes land in the data phase; hardware sets win over clears below.
      if (s_reg.wpend) begin
         if (s_reg.waddr == CTRL_OFS) begin
            s_next.force_on = hwdata[FORCE_BIT];
            s_next.duty     = hwdata[DUTY_LSB +: 2];
            s_next.ov_en    = hwdata[OVEN_BIT];
            s_next.cfg      = hwdata[CFG_LSB +: 2];
         end else if (s_reg.waddr == GPIO_OFS) begin
            s_next.fn = hwdata[3:0];
            s_next.sw = hwdata[SW_LSB +: 2];
         end else if (s_reg.waddr == STAT_OFS) begin
            if (hwdata[FAIL_BIT]) begin
               s_next.fail_flag = 1'b0;
            end
         end else if (s_reg.waddr == WAKE_OFS) begin
            s_next.wake2 = s_reg.wake2 & ~hwdata[1:0];
         end
      end

      if (other_evt || (wd_act && wd_flag_ok)) begin
         s_next.fail_flag = 1'b1;
      end
      if (wdog_miss_flag_evt) begin
         s_next.miss = 1'b1;
      end else if (wd_trig_ok || sleep_entry || wd_off_in_stop || other_evt) begin
         s_next.miss = 1'b0;
      end
      // The hold is the failure side of the outputs; the force bit is kept apart.
      if (other_evt || wd_act) begin
         s_next.hold = 1'b1;
      end else if (!cond && !s_reg.fail_flag && !s_reg.miss) begin
         s_next.hold = 1'b0;
      end
      s_next.fsafe = other_evt || (wd_act && s_reg.cfg[0]);

      // Waveforms.
      s_next.fail_out_force = s_reg.hold || s_reg.force_on;
      if (s_next.fail_out_force && !s_reg.fail_out_force) begin
         s_next.blink_cnt = 32'h0;
         s_next.blink_ph  = 1'b1;
         s_next.pwm_cnt   = 32'h0;
      end else begin
         if (s_reg.blink_cnt >= BLINK_LAST) begin
            s_next.blink_cnt = 32'h0;
            s_next.blink_ph  = !s_reg.blink_ph;
         end else begin
            s_next.blink_cnt = s_reg.blink_cnt + 32'h1;
         end
         if (s_reg.pwm_cnt >= PWM_LAST) begin
            s_next.pwm_cnt = 32'h0;
         end else begin
            s_next.pwm_cnt = s_reg.pwm_cnt + 32'h1;
         end
      end
      thr    = DUTY_STEP << (2'h3 - s_reg.duty);
      lamp_b = s_reg.fail_out_force && s_reg.blink_ph;
      lamp_d = s_reg.fail_out_force && (s_reg.pwm_cnt < thr);
      lamp   = {lamp_d, lamp_b};
      s_next.st_oe_n = !s_reg.fail_out_force;

      // Pins.
      for (int i = 0; i < 2; i++) begin
         if ((sbc_mode == MODE_NORMAL) || (sbc_mode == MODE_STOP)) begin
            s_next.lvl[i] = pins[i];
         end
         s_next.prev[i] = pins[i];
         if ((s_reg.fn[i] == FN_WAKE) && (sbc_mode != MODE_FSAFE) && (pins[i] != s_reg.prev[i])) begin
            s_next.wake2[i] = 1'b1;
         end
         if (s_reg.fn[i] == FN_FAIL) begin
            s_next.gp_o[i]    = 1'b0;
            s_next.gp_oe_n[i] = !lamp[i];
         end else if (s_reg.fn[i] == FN_WAKE) begin
            s_next.gp_o[i]    = 1'b0;
            s_next.gp_oe_n[i] = 1'b1;
         end else if ((sbc_mode == MODE_SLEEP) || (sbc_mode == MODE_FSAFE)) begin
            s_next.gp_o[i]    = 1'b0;
            s_next.gp_oe_n[i] = 1'b1;
         end else if (sbc_mode == MODE_NORMAL) begin
            s_next.gp_o[i]    = (s_reg.fn[i] == FN_HS);
            s_next.gp_oe_n[i] = !s_reg.sw[i];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg          <= '0;
         s_reg.rdy      <= 1'b1;
         s_reg.duty     <= DUTY_RST;
         s_reg.cfg      <= CFG_RST;
         s_reg.fn       <= {FN_RST, FN_RST};
         s_reg.st_oe_n  <= 1'b1;
         s_reg.gp_oe_n  <= 2'h3;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hrdata               = s_reg.rdata;
   assign hreadyout            = s_reg.rdy;
   assign hresp                = 1'b0;
   assign static_fail_out_oe_n = s_reg.st_oe_n;
   assign blink_fail_out_o     = s_reg.gp_o[0];
   assign blink_fail_out_oe_n  = s_reg.gp_oe_n[0];
   assign dimmed_fail_out_o    = s_reg.gp_o[1];
   assign dimmed_fail_out_oe_n = s_reg.gp_oe_n[1];
   assign failsafe_req         = s_reg.fsafe;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence force_rise;
      $rose(s_reg.force_on) && !s_reg.hold;
   endsequence
   sequence static_low_after;
      ##2 !static_fail_out_oe_n;
   endsequence

   a_force_static_low: assert property (force_rise |-> static_low_after)
      else $error("force bit did not pull the static output low");
   a_ov_gated: assert property ((core_supply_ov && !s_reg.ov_en && !thermal_stage_two && !core_supply_short
      && !core_supply_uv_evt && !wdog_miss_flag_evt && !s_reg.fail_flag) |=> !s_reg.fail_flag)
      else $error("overvoltage set the flag while disabled");
   a_uv_fourth: assert property ((core_supply_uv_evt && s_reg.uv_cnt == 3'h3 && !core_supply_uv_ok)
      |=> s_reg.fail_flag && s_reg.hold)
      else $error("fourth undervoltage did not activate");
   a_wd_first_late: assert property ((wdog_miss_flag_evt && s_reg.cfg[1] && s_reg.wd_cnt == 2'h0 && !s_reg.hold
      && !cond && !uv4) |=> !s_reg.hold)
      else $error("first watchdog failure activated in config 3 or 4");
   a_cfg2_no_flag: assert property ((wdog_miss_flag_evt && s_reg.cfg == 2'h1 && s_reg.wd_cnt == 2'h0
      && !s_reg.fail_flag && !cond && !uv4) |=> !s_reg.fail_flag && s_reg.hold)
      else $error("config 2 first watchdog failure misbehaved");
   // A miss alone does not activate in configs 3 and 4, so only an active hold is guarded.
   a_hold_needs_clear: assert property (s_reg.hold && (s_reg.fail_flag || s_reg.miss) |=> s_reg.hold)
      else $error("outputs released while a flag is set");
   a_sleep_miss_clear: assert property ((sleep_entry && !wdog_miss_flag_evt) |=> !s_reg.miss)
      else $error("sleep entry left the miss flag set");
   a_failsafe_req: assert property (other_evt |=> failsafe_req)
      else $error("failure did not request fail-safe");
   a_wave_restart: assert property ($rose(s_reg.fail_out_force) |-> s_reg.blink_cnt == 32'h0
      && s_reg.pwm_cnt == 32'h0 && s_reg.blink_ph)
      else $error("waveforms not restarted in phase");
   a_sleep_switch_off: assert property ((sbc_mode == MODE_SLEEP && s_reg.fn[0] == FN_LS)
      |=> blink_fail_out_oe_n)
      else $error("switch pin left on in sleep");
   a_level_follow: assert property ((sbc_mode == MODE_NORMAL) |=> s_reg.lvl == $past(pins))
      else $error("level status did not follow the pins");

   sequence hold_dropped;
      $fell(s_reg.hold);
   endsequence
   sequence clean_before;
      !$past(s_reg.fail_flag) && !$past(s_reg.miss) && !$past(cond);
   endsequence

   a_release_clean: assert property (hold_dropped |-> clean_before)
      else $error("outputs released with a condition or flag pending");
   a_static_on: assert property (s_reg.fail_out_force |=> !static_fail_out_oe_n)
      else $error("static output not pulled low while active");
   a_force_on: assert property (s_reg.force_on |=> s_reg.fail_out_force)
      else $error("force bit did not activate the outputs");
   a_flag_set_wins: assert property ((other_evt && s_reg.wpend && s_reg.waddr == STAT_OFS) |=> s_reg.fail_flag)
      else $error("flag clear won over a failure event");
   a_blink_bound: assert property (s_reg.blink_cnt <= BLINK_LAST)
      else $error("blink counter ran past its period");
   a_pwm_bound: assert property (s_reg.pwm_cnt <= PWM_LAST)
      else $error("pwm counter ran past its period");
   a_dimmed_duty: assert property ((s_reg.fn[1] == FN_FAIL && s_reg.fail_out_force && s_reg.pwm_cnt >= thr)
      |=> dimmed_fail_out_oe_n)
      else $error("dimmed output low outside its duty window");
   a_stop_keeps: assert property ((sbc_mode == MODE_STOP && s_reg.fn[0] != FN_FAIL && s_reg.fn[0] != FN_WAKE)
      |=> $stable(blink_fail_out_oe_n))
      else $error("switch pin changed in stop mode");
   a_wake_record: assert property ((s_reg.fn[0] == FN_WAKE && sbc_mode != MODE_FSAFE
      && blink_pin_in != s_reg.prev[0]) |=> s_reg.wake2[0])
      else $error("wake edge not recorded");
endmodule

//--- testbench/fail_pins_model.sv
// Lamps, loads and wake sources hanging on the three fail output pins.
`timescale 1ns/1ps
module fail_pins_model (
   input  wire logic static_oe_n,
   input  wire logic blink_o,
   input  wire logic blink_oe_n,
   input  wire logic dimmed_o,
   input  wire logic dimmed_oe_n,
   input  wire logic src_en,
   input  wire logic src_lvl,
   output logic      static_pin,
   output logic      blink_pin,
   output logic      dimmed_pin
);
   // Released pins sit on their pull-ups unless the wake source is enabled, so the test strap reads high through power-up.
   assign static_pin = static_oe_n ? 1'b1 : 1'b0;
   assign blink_pin  = !blink_oe_n ? blink_o : (src_en ? src_lvl : 1'b1);
   assign dimmed_pin = !dimmed_oe_n ? dimmed_o : (src_en ? src_lvl : 1'b1);
endmodule

//--- testbench/fail_out_signaling_tb_top.sv
// Register-level tests of the fail output signalling block.
`timescale 1ns/1ps
module fail_out_signaling_tb_top;
   import fail_out_pkg::*;
   localparam longint BH = 20;
   localparam longint PP = 400;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, failsafe_req, saw_fs;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, sbc_mode;
   logic [2:0]  hsize;
   logic        wdog_miss_flag_evt, wd_trig_ok, wd_off_in_stop, sleep_entry, core_supply_uv_evt, core_supply_uv_ok;
   logic        thermal_stage_two, core_supply_short, core_supply_ov, src_en, src_lvl;
   logic        blink_pin_in, dimmed_out_test_strap_pin, static_pin;
   logic        st_oe_n, bl_o, bl_oe_n, dm_o, dm_oe_n;
   int          n_mismatch, n_tests, cyc, c;
   fail_out_signaling #(.BLINK_HALF(BH), .PWM_PERIOD(PP)) DUT (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
      .hresp, .sbc_mode, .wdog_miss_flag_evt, .wd_trig_ok, .wd_off_in_stop, .sleep_entry, .thermal_stage_two,
      .core_supply_short, .core_supply_ov, .core_supply_uv_evt, .core_supply_uv_ok, .blink_pin_in,
      .dimmed_out_test_strap_pin, .static_fail_out_oe_n(st_oe_n), .blink_fail_out_o(bl_o),
      .blink_fail_out_oe_n(bl_oe_n), .dimmed_fail_out_o(dm_o), .dimmed_fail_out_oe_n(dm_oe_n), .failsafe_req);
   fail_pins_model pins (.static_oe_n(st_oe_n), .blink_o(bl_o), .blink_oe_n(bl_oe_n), .dimmed_o(dm_o),
      .dimmed_oe_n(dm_oe_n), .src_en(src_en), .src_lvl(src_lvl), .static_pin(static_pin),
      .blink_pin(blink_pin_in), .dimmed_pin(dimmed_out_test_strap_pin));
   assign hready = hreadyout;
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // The ceiling sits well above the few thousand cycles the sequence needs.
   always @(posedge hclk) begin
      if (failsafe_req === 1'b1) saw_fs <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic s);
      chk(n, {31'h0, e}, {31'h0, s});
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= w ? d : 32'h0;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
      repeat (5) @(posedge hclk);
   endtask
   task automatic rdm(input string n, input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(n, e, r & m);
   endtask
   task automatic pulse(input int k);
      @(posedge hclk);
      case (k)
         0: wdog_miss_flag_evt <= 1'b1;
         1: wd_trig_ok <= 1'b1;
         2: sleep_entry <= 1'b1;
         3: wd_off_in_stop <= 1'b1;
         4: core_supply_uv_evt <= 1'b1;
         default: core_supply_uv_ok <= 1'b1;
      endcase
      @(posedge hclk);
      {wdog_miss_flag_evt, wd_trig_ok, sleep_entry, wd_off_in_stop, core_supply_uv_evt, core_supply_uv_ok} <= 6'h0;
      repeat (5) @(posedge hclk);
   endtask
   task automatic lows(input int sel, input int n, output int cnt);
      cnt = 0;
      repeat (n) begin
         @(posedge hclk);
         cnt += ((sel == 0 ? bl_oe_n : dm_oe_n) === 1'b0);
      end
   endtask
   task automatic mode(input logic [1:0] m);
      @(posedge hclk);
      sbc_mode <= m;
      repeat (5) @(posedge hclk);
   endtask
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, sbc_mode, saw_fs, src_en, cyc, n_mismatch, n_tests} = '0;
      {wdog_miss_flag_evt, wd_trig_ok, sleep_entry, wd_off_in_stop, core_supply_uv_evt, core_supply_uv_ok} = 6'h0;
      {thermal_stage_two, core_supply_short, core_supply_ov} = 3'h0;
      hsize = 3'h2;
      src_lvl = 1'b1;
      hresetn = 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rdm("ctrl reset", CTRL_OFS, 32'hffffffff, 32'h0);
      chk1("okay response", 1'b0, hresp);
      rdm("pin ctrl reset", GPIO_OFS, 32'hffffffff, 32'h0);
      rdm("status reset", STAT_OFS, 32'hffffffff, 32'h0);
      rdm("unmapped", 32'h40, 32'hffffffff, 32'h0);
      chk1("static idle", 1'b1, st_oe_n);
      wr(CTRL_OFS, 32'h1);
      chk1("static forced", 1'b0, st_oe_n);
      chk1("blink in phase", 1'b0, bl_oe_n);
      chk1("dimmed in phase", 1'b0, dm_oe_n);
      for (int d = 0; d < 4; d++) begin
         wr(CTRL_OFS, 32'h1 | (d << DUTY_LSB));
         lows(1, PP, c);
         chk("pwm low cycles", PP / (5 << d), c);
      end
      lows(0, 2 * BH, c);
      chk("blink low cycles", BH, c);
      rdm("flag after force", STAT_OFS, 32'h1, 32'h0);
      wr(CTRL_OFS, 32'h0);
      chk1("force off", 1'b1, st_oe_n);
      chk1("static pin high", 1'b1, static_pin);
      for (int k = 0; k < 2; k++) begin
         saw_fs = 1'b0;
         @(posedge hclk);
         if (k == 0) thermal_stage_two <= 1'b1;
         else core_supply_short <= 1'b1;
         repeat (5) @(posedge hclk);
         chk1("level fail on", 1'b0, st_oe_n);
         chk1("fail-safe request", 1'b1, saw_fs);
         rdm("fail flag", STAT_OFS, 32'h1, 32'h1);
         wr(STAT_OFS, 32'h1);
         @(posedge hclk);
         {thermal_stage_two, core_supply_short} <= 2'h0;
         repeat (5) @(posedge hclk);
         chk1("held while flag", 1'b0, st_oe_n);
         wr(STAT_OFS, 32'h1);
         chk1("released", 1'b1, st_oe_n);
      end
      @(posedge hclk);
      core_supply_ov <= 1'b1;
      repeat (5) @(posedge hclk);
      chk1("ov ignored", 1'b1, st_oe_n);
      wr(CTRL_OFS, 32'h1 << OVEN_BIT);
      chk1("ov enabled", 1'b0, st_oe_n);
      @(posedge hclk);
      core_supply_ov <= 1'b0;
      wr(CTRL_OFS, 32'h0);
      wr(STAT_OFS, 32'h1);
      repeat (3) pulse(4);
      pulse(5);
      repeat (3) pulse(4);
      chk1("uv not consecutive", 1'b1, st_oe_n);
      pulse(4);
      chk1("uv fourth", 1'b0, st_oe_n);
      pulse(5);
      wr(STAT_OFS, 32'h1);
      for (int g = 0; g < 4; g++) begin
         wr(CTRL_OFS, g << CFG_LSB);
         pulse(1);
         saw_fs = 1'b0;
         pulse(0);
         if (g >= 2) begin
            chk1("first wdog_miss_flag", 1'b1, st_oe_n);
            pulse(0);
         end
         chk1("wdog_miss_flag on", 1'b0, st_oe_n);
         chk1("wdog_miss_flag-safe", g == 1 || g == 3, saw_fs);
         rdm("wd flags", STAT_OFS, 32'h3, g == 1 ? 32'h2 : 32'h3);
         wr(STAT_OFS, 32'h1);
         chk1("miss holds", 1'b0, st_oe_n);
         if (g == 3) mode(MODE_STOP);
         pulse(g < 2 ? 1 : g);
         mode(MODE_NORMAL);
         rdm("miss cleared", STAT_OFS, 32'h2, 32'h0);
         wr(STAT_OFS, 32'h1);
         chk1("wd released", 1'b1, st_oe_n);
      end
      wr(GPIO_OFS, FN_LS | (FN_HS << 2) | (32'h3 << SW_LSB));
      rdm("switch levels", LVL_OFS, 32'h3, 32'h2);
      mode(MODE_STOP);
      rdm("stop levels", LVL_OFS, 32'h3, 32'h2);
      mode(MODE_SLEEP);
      chk1("sleep ls off", 1'b1, bl_oe_n);
      chk1("sleep hs off", 1'b1, dm_oe_n);
      mode(MODE_NORMAL);
      wr(GPIO_OFS, FN_WAKE | (FN_WAKE << 2));
      src_en <= 1'b1;
      repeat (3) @(posedge hclk);
      src_lvl <= 1'b0;
      repeat (6) @(posedge hclk);
      rdm("wake events", WAKE_OFS, 32'h3, 32'h3);
      rdm("wake levels", LVL_OFS, 32'h3, 32'h0);
      wr(WAKE_OFS, 32'h3);
      rdm("wake cleared", WAKE_OFS, 32'h3, 32'h0);
      close_out();
   end
endmodule
